// ==== design/fcsm_pkg.sv ====
// constants, register map and types of the cyclic slot mapper
package fcsm_pkg;
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_DICH    = 8'h04;
  localparam logic [7:0] REG_STATION = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0c;
  localparam logic [7:0] REG_COMP    = 8'h10;
  localparam logic [7:0] REG_COMPST  = 8'h14;
  localparam logic [7:0] REG_AOCH    = 8'h18;

  localparam int N_DO       = 4;
  localparam int N_FUNC     = 4;
  localparam int CH_W       = 11;
  localparam int ADR_W      = 7;
  localparam int FIFO_DEPTH = 4;

  // slot enable bits: bit i stands for slot 10+i
  localparam logic [6:0] CTRL_RST       = 7'h7f;
  localparam int         CFG_AO         = 0;
  localparam int         CFG_DI1        = 1;
  localparam int         CFG_DI2        = 2;
  localparam int         CFG_DO1        = 3;
  localparam int         CTRL_PAUSE_BIT = 8;
  localparam int         DICH2_LSB      = 16;

  localparam logic [CH_W-1:0] CH_SWITCH  = 11'h37d;
  localparam logic [CH_W-1:0] CH_EMPTY   = 11'h37e;
  localparam logic [CH_W-1:0] CH_LOWFLOW = 11'h37f;
  localparam logic [CH_W-1:0] CH_VERIF   = 11'h596;
  localparam logic [CH_W-1:0] AO_CHANNEL = 11'h132;
  localparam logic [CH_W-1:0] DICH1_RST  = 11'h37e;
  localparam logic [CH_W-1:0] DICH2_RST  = 11'h37f;

  localparam logic [ADR_W-1:0] STATION_DEFAULT = 7'h7e;

  localparam int ST_REJ   = 0;
  localparam int ST_FERR  = 1;
  localparam int ST_HWSEL = 2;
  localparam int ST_DRAIN = 3;
  localparam int ST_DOEN  = 4;

  localparam logic [2:0] AO_LEN   = 3'h5;
  localparam logic [2:0] DO_LEN   = 3'h2;
  localparam logic [2:0] SEG_AO   = 3'h0;
  localparam logic [2:0] SEG_DONE = 3'h5;
  localparam logic [2:0] TX_PAIR  = 3'h2;

  localparam logic [7:0] VAL_OFF   = 8'h00;
  localparam logic [7:0] VAL_ON    = 8'h01;
  localparam logic [7:0] STAT_GOOD = 8'h80;
  localparam logic [7:0] STAT_BAD  = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PS_RUN   = 2'b01,
    PS_DRAIN = 2'b10
  } fcsm_pstate_t;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } fcsm_rx_t;

  typedef struct packed {
    logic [31:0] value;
    logic [7:0]  status;
  } fcsm_comp_t;

  typedef struct packed {
    logic       enable;
    logic [7:0] status;
  } fcsm_do_t;
endpackage : fcsm_pkg

// ==== design/fcsm_top.sv ====
// byte fifo and the cyclic slot mapper top level
//
// The register offsets and register access over AXI4-Lite were left to the implementer.

// pointer arithmetic wraps, so depth must be a power of two
module fcsm_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [PW:0]  wr_q;
  logic [PW:0]  rd_q;
  logic [PW:0]  used;

  assign used      = wr_q - rd_q;
  assign in_ready  = used != FULL;
  assign out_valid = used != '0;
  assign out_data  = mem_q[rd_q[PW-1:0]];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_q <= '0;
    end else if (in_valid && in_ready) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem_q[wr_q[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_q <= '0;
    end else if (out_valid && out_ready) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule : fcsm_fifo

module fcsm_top import fcsm_pkg::*; (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              rx_valid,
  output logic                   rx_ready,
  input  wire fcsm_rx_t          rx_byte,
  input  wire logic              tx_start,
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output logic [7:0]             tx_data,
  output logic                   tx_last,
  input  wire logic [N_FUNC-1:0] func_active,
  input  wire logic              verif_present,
  input  wire logic              hw_addr_sel,
  output logic [ADR_W-1:0]       station_addr,
  output fcsm_comp_t             comp,
  output logic                   comp_valid,
  output fcsm_do_t [N_DO-1:0]    do_out
);
  function automatic logic [2:0] next_seg(input logic [2:0] from, input logic [4:0] m);
    logic [2:0] r;
    r = SEG_DONE;
    for (int i = 4; i >= 0; i--) begin
      if (m[i] && (3'(i) >= from)) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : next_seg

  function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = cur;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [15:0] di_pair(input logic [CH_W-1:0] ch,
                                          input logic [N_FUNC-1:0] act, input logic vp);
    logic [15:0] r;
    r = {VAL_OFF, STAT_BAD};
    case (ch)
      CH_SWITCH:  r = {act[0] ? VAL_ON : VAL_OFF, STAT_GOOD};
      CH_EMPTY:   r = {act[1] ? VAL_ON : VAL_OFF, STAT_GOOD};
      CH_LOWFLOW: r = {act[2] ? VAL_ON : VAL_OFF, STAT_GOOD};
      // verification status only exists with the option fitted
      CH_VERIF:   r = vp ? {act[3] ? VAL_ON : VAL_OFF, STAT_GOOD} : {VAL_OFF, STAT_BAD};
      default:    r = {VAL_OFF, STAT_BAD};
    endcase
    return r;
  endfunction : di_pair

  logic              aw_hold_q;
  logic [7:0]        awaddr_q;
  logic              w_hold_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic [7:0]        wa;
  logic [31:0]       wd;
  logic [3:0]        ws;
  logic              do_wr;
  logic [31:0]       rd_d;
  logic [1:0]        rresp_d;
  logic [6:0]        cfg_q;
  logic              pause_q;
  logic [CH_W-1:0]   dich1_q;
  logic [CH_W-1:0]   dich2_q;
  logic [ADR_W-1:0]  station_q;
  logic              rej_q;
  logic              ferr_q;
  logic [31:0]       w_ctrl;
  logic [31:0]       w_dich;
  logic [31:0]       w_stat;
  fcsm_pstate_t      pst_q;
  logic [2:0]        seg_q;
  logic [2:0]        byte_q;
  logic [4:0]        mask_q;
  logic [4:0]        cm_q;
  logic              commit_q;
  logic [7:0]        ao_sh [5];
  logic [7:0]        do_sh [N_DO][2];
  logic [2:0]        do_idx;
  logic              f_valid;
  logic              f_ready;
  fcsm_rx_t          f_byte;
  logic              pop;
  logic              fin;
  logic              seg_end;
  logic [2:0]        nseg;
  logic              good;
  logic [4:0]        cur_mask;
  fcsm_comp_t        comp_q;
  logic              comp_valid_q;
  fcsm_do_t [N_DO-1:0] do_q;
  logic [2:0]        tx_cnt_q;
  logic [31:0]       tx_sh_q;
  logic              start_ok;
  logic [15:0]       di1;
  logic [15:0]       di2;

  // ---- AXI4-Lite slave: address and data taken in either order
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  assign wa    = aw_hold_q ? awaddr_q : s_axi_awaddr;
  assign wd    = w_hold_q ? wdata_q : s_axi_wdata;
  assign ws    = w_hold_q ? wstrb_q : s_axi_wstrb;
  assign do_wr = (aw_hold_q || s_axi_awvalid) && (w_hold_q || s_axi_wvalid) && !bvalid_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
      w_hold_q  <= 1'b0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else if (do_wr) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b1;
      bresp_q   <= (wa <= REG_AOCH && wa[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_d    = '0;
    rresp_d = RESP_OKAY;
    case (s_axi_araddr)
      REG_CTRL: begin
        rd_d[6:0]            = cfg_q;
        rd_d[CTRL_PAUSE_BIT] = pause_q;
      end
      REG_DICH: begin
        rd_d[CH_W-1:0]            = dich1_q;
        rd_d[DICH2_LSB +: CH_W]   = dich2_q;
      end
      REG_STATION: rd_d[ADR_W-1:0] = station_q;
      REG_STATUS: begin
        rd_d[ST_REJ]           = rej_q;
        rd_d[ST_FERR]          = ferr_q;
        rd_d[ST_HWSEL]         = hw_addr_sel;
        rd_d[ST_DRAIN]         = pst_q == PS_DRAIN;
        for (int i = 0; i < N_DO; i++) begin
          rd_d[ST_DOEN+i] = do_q[i].enable;
        end
      end
      REG_COMP:   rd_d = comp_q.value;
      REG_COMPST: rd_d[7:0] = comp_q.status;
      REG_AOCH:   rd_d[CH_W-1:0] = AO_CHANNEL;
      default:    rresp_d = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_d;
      rresp_q  <= rresp_d;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---- configuration registers
  assign w_ctrl = merge({23'h0, pause_q, 1'b0, cfg_q}, wd, ws);
  assign w_dich = merge({5'h0, dich2_q, 5'h0, dich1_q}, wd, ws);
  assign w_stat = merge(32'h0, wd, ws);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_q   <= CTRL_RST;
      pause_q <= 1'b0;
      dich1_q <= DICH1_RST;
      dich2_q <= DICH2_RST;
    end else if (do_wr && wa == REG_CTRL) begin
      cfg_q   <= w_ctrl[6:0];
      pause_q <= w_ctrl[CTRL_PAUSE_BIT];
    end else if (do_wr && wa == REG_DICH) begin
      dich1_q <= w_dich[CH_W-1:0];
      dich2_q <= w_dich[DICH2_LSB +: CH_W];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      station_q <= STATION_DEFAULT;
    end else if (do_wr && wa == REG_STATION && !hw_addr_sel && ws[0]) begin
      station_q <= wd[ADR_W-1:0];
    end
  end
  assign station_addr = station_q;

  // sticky flags: a new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rej_q <= 1'b0;
    end else if (do_wr && wa == REG_STATION && hw_addr_sel && ws[0]) begin
      rej_q <= 1'b1;
    end else if (do_wr && wa == REG_STATUS && w_stat[ST_REJ]) begin
      rej_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ferr_q <= 1'b0;
    end else if (pop && pst_q == PS_RUN && (seg_q == SEG_DONE || (fin && !good))) begin
      ferr_q <= 1'b1;
    end else if (do_wr && wa == REG_STATUS && w_stat[ST_FERR]) begin
      ferr_q <= 1'b0;
    end
  end

  // ---- output frame from the master, buffered; the pause bit stalls the parser
  fcsm_fifo #(
    .W     ($bits(fcsm_rx_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .in_data   (rx_byte),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_byte)
  );

  assign f_ready  = !pause_q;
  assign pop      = f_valid && f_ready;
  assign fin      = pop && f_byte.last;
  assign cur_mask = {cfg_q[6:CFG_DO1], cfg_q[CFG_AO]};
  assign seg_end  = byte_q == ((seg_q == SEG_AO) ? AO_LEN : DO_LEN) - 3'h1;
  assign nseg     = next_seg(seg_q + 3'h1, mask_q);
  assign good     = pst_q == PS_RUN && seg_q != SEG_DONE && seg_end && nseg == SEG_DONE;
  assign do_idx   = seg_q - 3'h1;

  // the slot map is sampled at frame boundaries so a reconfiguration never splits a frame
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pst_q  <= PS_RUN;
      seg_q  <= SEG_AO;
      byte_q <= '0;
      mask_q <= {CTRL_RST[6:CFG_DO1], CTRL_RST[CFG_AO]};
    end else if (pop) begin
      case (pst_q)
        PS_RUN: begin
          if (fin) begin
            seg_q  <= next_seg(3'h0, cur_mask);
            byte_q <= '0;
            mask_q <= cur_mask;
          end else if (seg_q == SEG_DONE) begin
            pst_q <= PS_DRAIN;
          end else if (seg_end) begin
            seg_q  <= nseg;
            byte_q <= '0;
          end else begin
            byte_q <= byte_q + 3'h1;
          end
        end
        PS_DRAIN: begin
          if (fin) begin
            pst_q  <= PS_RUN;
            seg_q  <= next_seg(3'h0, cur_mask);
            byte_q <= '0;
            mask_q <= cur_mask;
          end
        end
        default: pst_q <= PS_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (pop && pst_q == PS_RUN && seg_q != SEG_DONE) begin
      if (seg_q == SEG_AO) begin
        ao_sh[byte_q] <= f_byte.data;
      end else begin
        do_sh[do_idx[1:0]][byte_q[0]] <= f_byte.data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      commit_q <= 1'b0;
      cm_q     <= '0;
    end else begin
      commit_q <= fin && good;
      cm_q     <= mask_q;
    end
  end

  // only whole frames reach the outputs; a malformed one leaves them untouched
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      comp_q       <= '0;
      comp_valid_q <= 1'b0;
    end else begin
      comp_valid_q <= commit_q && cm_q[0];
      if (commit_q && cm_q[0]) begin
        comp_q.value  <= {ao_sh[0], ao_sh[1], ao_sh[2], ao_sh[3]};
        comp_q.status <= ao_sh[4];
      end
    end
  end
  assign comp       = comp_q;
  assign comp_valid = comp_valid_q;

  // four output slots
  // index 0 flow override, 1 zero point, 2 pulse/switch output, 3 start verification
  generate
    for (genvar i = 0; i < N_DO; i++) begin : g_do
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          do_q[i] <= '0;
        end else if (commit_q && cm_q[i+1]) begin
          do_q[i].status <= do_sh[i][1];
          if (do_sh[i][0] == VAL_ON) begin
            do_q[i].enable <= 1'b1;
          end else if (do_sh[i][0] == VAL_OFF) begin
            do_q[i].enable <= 1'b0;
          end
        end
      end
    end
  endgenerate
  assign do_out = do_q;

  // ---- input frame to the master
  assign di1      = di_pair(dich1_q, func_active, verif_present);
  assign di2      = di_pair(dich2_q, func_active, verif_present);
  assign start_ok = tx_start && tx_cnt_q == 3'h0;
  assign tx_valid = tx_cnt_q != 3'h0;
  assign tx_last  = tx_cnt_q == 3'h1;
  assign tx_data  = tx_sh_q[31:24];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_cnt_q <= '0;
      tx_sh_q  <= '0;
    end else if (start_ok) begin
      tx_cnt_q <= (cfg_q[CFG_DI1] ? TX_PAIR : 3'h0) + (cfg_q[CFG_DI2] ? TX_PAIR : 3'h0);
      tx_sh_q  <= cfg_q[CFG_DI1] ? {di1, di2} : {di2, 16'h0};
    end else if (tx_valid && tx_ready) begin
      tx_cnt_q <= tx_cnt_q - 3'h1;
      tx_sh_q  <= {tx_sh_q[23:0], 8'h00};
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_station_default: assert property ($fell(sys_rst) |-> station_q == STATION_DEFAULT)
    else $error("station address not at factory default after reset");
  a_station_locked: assert property (
    do_wr && wa == REG_STATION && hw_addr_sel && ws[0] |=> $stable(station_q) && rej_q)
    else $error("station address changed under hardware addressing");
  a_do_enable: assert property (
    commit_q && cm_q[1] && do_sh[0][0] == VAL_ON |=> do_out[0].enable)
    else $error("discrete output not enabled by value one");
  a_comp_slot: assert property (comp_valid |-> $past(cm_q[0]) && $past(commit_q))
    else $error("compensation update without analog output slot");
  a_empty_tx: assert property (
    start_ok && cfg_q[2:1] == 2'b00 |=> !tx_valid [*2])
    else $error("bytes sent for empty input slots");
  a_di_value: assert property (
    tx_valid && !tx_cnt_q[0] |-> tx_data == VAL_OFF || tx_data == VAL_ON)
    else $error("discrete input value byte not zero or one");
  a_tx_length: assert property (
    start_ok && cfg_q[2:1] == 2'b11 |=> tx_cnt_q == 3'h4 && tx_valid)
    else $error("input frame not four bytes");
  a_frame_error: assert property (
    pop && pst_q == PS_RUN && seg_q == SEG_DONE |=>
      ferr_q && (pst_q == PS_DRAIN || $past(fin)))
    else $error("overlong output frame not flagged");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
endmodule : fcsm_top

// ==== verification/fcsm_master_model.sv ====
// far-side bus master model: feeds output frames and takes input frames
module fcsm_master_model import fcsm_pkg::*; (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output fcsm_rx_t        rx_byte,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last
);
  timeunit 1ns;
  timeprecision 1ps;
  fcsm_rx_t   q[$];
  logic [8:0] got[$];
  bit         slow;
  logic       rdy_s;
  // sample at the falling edge so the rising edge sees settled values
  always @(negedge clk) begin
    rdy_s = rx_ready;
    if (tx_valid && tx_ready) got.push_back({tx_last, tx_data});
  end
  always @(posedge clk) begin
    if (sys_rst) begin
      rx_valid <= 1'b0;
      rx_byte  <= '0;
    end else if (!rx_valid || rdy_s) begin
      if (q.size() > 0 && !(slow && $urandom_range(1) == 0)) begin
        rx_byte  <= q.pop_front();
        rx_valid <= 1'b1;
      end else begin
        rx_valid <= 1'b0;
        // released line shows garbage, not the last byte
        rx_byte  <= ~rx_byte;
      end
    end
    tx_ready <= !slow || $urandom_range(1) == 1;
  end
endmodule : fcsm_master_model

// ==== verification/tb_top.sv ====
// self-checking bench of the cyclic slot mapper
module tb_top import fcsm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                s_axi_rready, rx_valid, rx_ready, tx_start, tx_valid, tx_ready, tx_last;
  logic                verif_present, hw_addr_sel, comp_valid;
  logic [7:0]          s_axi_awaddr, s_axi_araddr, tx_data;
  logic [31:0]         s_axi_wdata, s_axi_rdata, d;
  logic [3:0]          s_axi_wstrb, func_active;
  logic [1:0]          s_axi_bresp, s_axi_rresp, r;
  logic [ADR_W-1:0]    station_addr;
  fcsm_rx_t            rx_byte;
  fcsm_comp_t          comp, ecomp;
  fcsm_do_t [N_DO-1:0] do_out;
  int                  n_mismatch, total_checks, mask, ncv, cvs;
  int                  den[4], dst[4];

  fcsm_top u_fcsm_top (.*);
  fcsm_master_model u_fcsm_master_model (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) if (comp_valid === 1'b1) cvs++;
  initial begin
    #500us;
    n_mismatch++;
    stop_test;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw, w, b;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w  = s_axi_wvalid && s_axi_wready;
      b  = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge clk);
    chk(b, 1);
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ar, rv;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    rv = 1'b0;
    while (!rv) begin
      @(negedge clk);
      ar = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      v  = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge clk);
    chk(rv, 1);
  endtask : axr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    axr(a, d, r);
    chk(d, e);
    chk(r, er);
  endtask : rdc

  // cut > 0 cuts the frame short (above 50: two bytes too long), cut < 0 replays state
  task automatic frame(input int cut);
    fcsm_rx_t    b[$];
    logic [31:0] f;
    logic [7:0]  s;
    int          v;
    f = (cut < 0) ? ecomp.value : $urandom();
    s = (cut < 0) ? ecomp.status : 8'($urandom());
    if (mask[0]) begin
      for (int i = 3; i >= 0; i--) b.push_back({1'b0, f[8*i+:8]});
      b.push_back({1'b0, s});
      if (cut == 0) ecomp = {f, s};
      if (cut == 0) ncv++;
    end
    for (int i = 0; i < 4; i++) begin
      v = (cut < 0) ? den[i] : $urandom_range(2);
      s = (cut < 0) ? 8'(dst[i]) : 8'($urandom());
      if (mask[3+i]) begin
        b.push_back({1'b0, v[7:0]});
        b.push_back({1'b0, s});
        if (cut == 0 && v < 2) den[i] = v;
        if (cut == 0) dst[i] = s;
      end
    end
    while (cut > 0 && b.size() > cut) void'(b.pop_back());
    if (cut > 50) repeat (2) b.push_back(9'h0);
    b[$].last = 1'b1;
    foreach (b[i]) u_fcsm_master_model.q.push_back(b[i]);
  endtask : frame

  task automatic settle;
    for (int n = 0; n < 200 && (u_fcsm_master_model.q.size() > 0 || rx_valid); n++)
      @(posedge clk);
    repeat (8) @(posedge clk);
  endtask : settle

  task automatic outchk;
    settle;
    chk(comp, ecomp);
    chk(cvs, ncv);
    rdc(REG_COMPST, ecomp.status, RESP_OKAY);
    for (int i = 0; i < 4; i++) chk(do_out[i], {den[i][0], dst[i][7:0]});
  endtask : outchk

  // the transition frame leaves outputs as they are whichever mask it meets
  task automatic remask(input int m);
    axw(REG_CTRL, m, r);
    frame(-1);
    settle;
    axw(REG_STATUS, 32'h2, r);
    mask = m;
    cvs = ncv;
  endtask : remask

  function automatic logic [8:0] di(input int ch);
    int k;
    k = (ch == 893) ? 0 : (ch == 894) ? 1 : (ch == 895) ? 2 : (ch == 1430 && verif_present) ? 3 : -1;
    return (k < 0) ? 9'h0 : {func_active[k], 8'h80};
  endfunction : di

  task automatic txchk(input int c1, input int c2);
    logic [8:0] e[$];
    logic [8:0] p1, p2;
    axw(REG_DICH, (c2 << 16) | c1, r);
    func_active <= 4'($urandom());
    verif_present <= 1'($urandom());
    u_fcsm_master_model.got.delete();
    @(posedge clk);
    tx_start <= 1'b1;
    @(posedge clk);
    tx_start <= 1'b0;
    p1 = di(c1);
    p2 = di(c2);
    if (mask[1]) e.push_back({1'b0, 7'h0, p1[8]});
    if (mask[1]) e.push_back({1'b0, p1[7:0]});
    if (mask[2]) e.push_back({1'b0, 7'h0, p2[8]});
    if (mask[2]) e.push_back({1'b0, p2[7:0]});
    if (e.size() > 0) e[$][8] = 1'b1;
    for (int n = 0; n < 60 && u_fcsm_master_model.got.size() < e.size(); n++) @(posedge clk);
    repeat (6) @(posedge clk);
    chk(u_fcsm_master_model.got.size(), e.size());
    foreach (e[i]) chk(u_fcsm_master_model.got[i], e[i]);
  endtask : txchk

  initial begin
    void'($urandom(32'hbb40));
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {tx_start, func_active, verif_present, hw_addr_sel} = '0;
    ecomp = '0;
    sys_rst = 1'b1;
    mask = 'h7f;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    chk(station_addr, 126);
    rdc(REG_CTRL, 32'h7f, RESP_OKAY);
    rdc(REG_DICH, (895 << 16) | 894, RESP_OKAY);
    rdc(REG_AOCH, 306, RESP_OKAY);
    rdc(8'h1c, 0, RESP_SLVERR);
    axw(8'h1c, 32'h0, r);
    chk(r, RESP_SLVERR);
    txchk(894, 895);
    txchk(893, 1430);
    txchk(1430, 7);
    axw(REG_STATION, 5, r);
    chk(station_addr, 5);
    chk(r, RESP_OKAY);
    hw_addr_sel <= 1'b1;
    axw(REG_STATION, 9, r);
    chk(station_addr, 5);
    axr(REG_STATUS, d, r);
    chk(d[2:0], 3'h5);
    hw_addr_sel <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      u_fcsm_master_model.slow = k[0];
      frame(0);
      if (k[1]) frame(0);
      outchk;
    end
    // absent slots carry no bytes: AO, DO1 and DO3 only
    remask(32'h29);
    frame(0);
    frame(0);
    outchk;
    txchk(894, 895);
    frame(3);
    frame(99);
    outchk;
    axr(REG_STATUS, d, r);
    chk(d[1], 1);
    axw(REG_STATUS, 32'h3, r);
    rdc(REG_STATUS, {d[31:2], 2'h0}, RESP_OKAY);
    // parser paused: buffer fills and refuses, then drains
    axw(REG_CTRL, 32'h129, r);
    frame(0);
    repeat (40) @(posedge clk);
    chk(rx_ready, 0);
    axw(REG_CTRL, 32'h29, r);
    outchk;
    stop_test;
  end
endmodule : tb_top
